// ### include/fspc_pkg.sv
// Constants, field positions and states for the flash self-programming control block.
// Assumes a single CPU clock of 40 MHz and an active-low asynchronous reset.
package fspc_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [1:0] FSPC_ADDR_CTRL = 2'h0;
    localparam logic [1:0] FSPC_ADDR_STATUS = 2'h1;
    localparam logic [1:0] FSPC_ADDR_LOCK = 2'h2;
    localparam logic [7:0] FSPC_CTRL_RESET = 8'h00;
    // ----------------------------------------
    // Control field positions
    // ----------------------------------------
    localparam int FSPC_BIT_STORE_EN = 0;
    localparam int FSPC_BIT_ERASE = 1;
    localparam int FSPC_BIT_WRITE = 2;
    localparam int FSPC_BIT_LOCK = 3;
    localparam int FSPC_BIT_REEN = 4;
    localparam int FSPC_BIT_BUSY = 6;
    localparam int FSPC_BIT_IRQ_EN = 7;
    // Accepted low-five-bit patterns
    localparam logic [4:0] FSPC_PAT_REEN = 5'h11;
    localparam logic [4:0] FSPC_PAT_LOCK = 5'h09;
    localparam logic [4:0] FSPC_PAT_WRITE = 5'h05;
    localparam logic [4:0] FSPC_PAT_ERASE = 5'h03;
    localparam logic [4:0] FSPC_PAT_LOAD = 5'h01;
    // ----------------------------------------
    // Timing, reset values and load-program pointers
    // ----------------------------------------
    localparam logic [2:0] FSPC_STORE_WIN = 3'h4;
    localparam logic [2:0] FSPC_READ_WIN = 3'h3;
    localparam logic [15:0] FSPC_APP_RESET_ADDR = 16'h0000;
    localparam logic [7:0] FSPC_LOCK_RESET = 8'hff;
    localparam logic [15:0] FSPC_PTR_FUSE_LO = 16'h0000;
    localparam logic [15:0] FSPC_PTR_LOCK = 16'h0001;
    localparam logic [15:0] FSPC_PTR_FUSE_HI = 16'h0003;

    typedef enum logic [3:0] {
        FSPC_IDLE = 4'b0001,
        FSPC_WINDOW = 4'b0010,
        FSPC_BUSY = 4'b0100,
        FSPC_DONE = 4'b1000
    } fspc_state_e;
endpackage

// ### rtl/fspc_ctrl.sv
// Self-programming controller: control register, enable windows, erase/write/lock sequencing.
// Assumes CPU store/load-program strobes are single-cycle and synchronous to i_clk.
module fspc_ctrl
    import fspc_pkg::*;
#(
    parameter int WORD_BITS = 6,
    parameter int PAGE_BITS = 7,
    parameter int OP_CYCLES = 16,
    parameter logic [15:0] BOOT_START_ADDR = 16'h1c00,
    parameter logic [PAGE_BITS-1:0] NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE = 7'h70
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_store,
    input wire logic i_load_prog,
    input wire logic [15:0] i_pointer,
    input wire logic [15:0] i_data_word,
    input wire logic i_global_irq_en,
    input wire logic i_eeprom_busy,
    input wire logic i_boot_vector_fuse,
    input wire logic [7:0] i_fuse_low,
    input wire logic [7:0] i_fuse_high,
    output logic [15:0] o_reset_vector,
    output logic o_irq,
    output logic o_cpu_halt,
    output logic o_rww_blocked,
    output logic [7:0] o_lpm_data,
    output logic o_lpm_valid,
    output logic o_flash_erase,
    output logic o_flash_write,
    output logic [PAGE_BITS-1:0] o_flash_page,
    output logic [15:0] o_buf_rd_data,
    output logic o_buf_rd_valid,
    input wire logic [WORD_BITS-1:0] i_buf_rd_sel
);
    fspc_state_e state, next_state;
    logic [7:0] ctrl, next_ctrl;
    logic [2:0] win_cnt, next_win_cnt;
    logic [2:0] rd_cnt, next_rd_cnt;
    logic [15:0] op_cnt, next_op_cnt;
    logic [PAGE_BITS-1:0] page, next_page;
    logic [7:0] lock_bits, next_lock_bits;
    logic [7:0] rdata, next_rdata;
    logic [7:0] lpm_data, next_lpm_data;
    logic lpm_valid, next_lpm_valid;
    logic halt, next_halt;
    logic buf_load, buf_clear;
    logic [15:0] buf_rd_data;
    logic buf_rd_valid;
    logic [15:0] reset_vector;
    logic irq;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic pattern_ok(input logic [4:0] p);
        pattern_ok = (p == FSPC_PAT_REEN) || (p == FSPC_PAT_LOCK) || (p == FSPC_PAT_WRITE)
                     || (p == FSPC_PAT_ERASE) || (p == FSPC_PAT_LOAD);
    endfunction

    function automatic logic [PAGE_BITS-1:0] page_of(input logic [15:0] ptr);
        page_of = ptr[WORD_BITS+PAGE_BITS:WORD_BITS+1];
    endfunction

    fspc_page_buffer #(
        .WORD_BITS(WORD_BITS)
    ) u_buf (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_load(buf_load),
        .i_clear(buf_clear),
        .i_word_sel(i_pointer[WORD_BITS:1]),
        .i_data(i_data_word),
        .i_rd_sel(i_buf_rd_sel),
        .o_rd_data(buf_rd_data),
        .o_rd_valid(buf_rd_valid)
    );

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_comb begin
        next_state = state;
        next_ctrl = ctrl;
        next_win_cnt = win_cnt;
        next_rd_cnt = rd_cnt;
        next_op_cnt = op_cnt;
        next_page = page;
        next_lock_bits = lock_bits;
        next_halt = halt;
        next_lpm_valid = 1'b0;
        next_lpm_data = lpm_data;
        buf_load = 1'b0;
        buf_clear = 1'b0;
        case (state)
            FSPC_IDLE: begin
                if (i_wr && i_addr == FSPC_ADDR_CTRL) begin
                    next_ctrl[FSPC_BIT_IRQ_EN] = i_wdata[FSPC_BIT_IRQ_EN];
                    // EEPROM write blocks opening a window
                    if (pattern_ok(i_wdata[4:0]) && !i_eeprom_busy) begin
                        next_ctrl[4:0] = i_wdata[4:0];
                        next_win_cnt = FSPC_STORE_WIN;
                        next_rd_cnt = FSPC_READ_WIN;
                        next_state = FSPC_WINDOW;
                    end
                end
            end
            FSPC_WINDOW: begin
                next_win_cnt = win_cnt - 3'h1;
                if (rd_cnt != 3'h0) begin
                    next_rd_cnt = rd_cnt - 3'h1;
                end
                if (i_wr && i_addr == FSPC_ADDR_CTRL) begin
                    next_ctrl[FSPC_BIT_IRQ_EN] = i_wdata[FSPC_BIT_IRQ_EN];
                    if (i_wdata[4:0] == FSPC_PAT_REEN && ctrl[4:0] == FSPC_PAT_LOAD) begin
                        // Loading interrupted: everything loaded is dropped
                        buf_clear = 1'b1;
                        next_ctrl[4:0] = 5'h00;
                        next_state = FSPC_IDLE;
                    end
                end
                if (i_load_prog && ctrl[4:0] == FSPC_PAT_LOCK && rd_cnt != 3'h0 && !i_eeprom_busy) begin
                    next_lpm_valid = 1'b1;
                    case (i_pointer)
                        FSPC_PTR_LOCK: next_lpm_data = lock_bits;
                        FSPC_PTR_FUSE_HI: next_lpm_data = i_fuse_high;
                        default: next_lpm_data = i_fuse_low;
                    endcase
                    next_ctrl[4:0] = 5'h00;
                    next_state = FSPC_IDLE;
                end else if (i_store && !i_eeprom_busy) begin
                    next_page = page_of(i_pointer);
                    next_op_cnt = 16'(OP_CYCLES);
                    case (ctrl[4:0])
                        FSPC_PAT_LOAD: begin
                            buf_load = 1'b1;
                            next_ctrl[FSPC_BIT_BUSY] = 1'b0;
                            next_ctrl[4:0] = 5'h00;
                            next_state = FSPC_IDLE;
                        end
                        FSPC_PAT_REEN: begin
                            next_ctrl[FSPC_BIT_BUSY] = 1'b0;
                            buf_clear = 1'b1;
                            next_ctrl[4:0] = 5'h00;
                            next_state = FSPC_IDLE;
                        end
                        FSPC_PAT_LOCK: begin
                            // Bits only move toward programmed
                            next_lock_bits = lock_bits & {2'h3, i_data_word[5:2], 2'h3};
                            next_ctrl[4:0] = 5'h00;
                            next_state = FSPC_IDLE;
                        end
                        default: begin
                            if (page_of(i_pointer) >= NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE) begin
                                next_halt = 1'b1;
                            end else begin
                                next_ctrl[FSPC_BIT_BUSY] = 1'b1;
                            end
                            next_state = FSPC_BUSY;
                        end
                    endcase
                end else if (win_cnt == 3'h1) begin
                    next_ctrl[4:0] = 5'h00;
                    next_state = FSPC_IDLE;
                end
            end
            FSPC_BUSY: begin
                next_op_cnt = op_cnt - 16'h0001;
                if (op_cnt == 16'h0001) begin
                    next_state = FSPC_DONE;
                end
            end
            FSPC_DONE: begin
                if (ctrl[FSPC_BIT_WRITE]) begin
                    buf_clear = 1'b1;
                end
                next_halt = 1'b0;
                next_ctrl[4:0] = 5'h00;
                next_state = FSPC_IDLE;
            end
            default: begin
                next_state = FSPC_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // Read path and outputs
    // ----------------------------------------
    always_comb begin
        next_rdata = 8'h00;
        if (i_rd) begin
            case (i_addr)
                FSPC_ADDR_CTRL: next_rdata = {ctrl[7:6], 1'b0, ctrl[4:0]};
                FSPC_ADDR_STATUS: next_rdata = {7'h00, halt};
                FSPC_ADDR_LOCK: next_rdata = lock_bits;
                default: next_rdata = 8'h00;
            endcase
        end
        // Fuse is read-only: no path lets the CPU change it
        reset_vector = i_boot_vector_fuse ? FSPC_APP_RESET_ADDR : BOOT_START_ADDR;
        irq = ctrl[FSPC_BIT_IRQ_EN] && i_global_irq_en && !ctrl[FSPC_BIT_STORE_EN];
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= FSPC_IDLE;
            ctrl <= FSPC_CTRL_RESET;
            win_cnt <= 3'h0;
            rd_cnt <= 3'h0;
            op_cnt <= 16'h0000;
            page <= '0;
            lock_bits <= FSPC_LOCK_RESET;
            rdata <= 8'h00;
            lpm_data <= 8'h00;
            lpm_valid <= 1'b0;
            halt <= 1'b0;
            o_reset_vector <= FSPC_APP_RESET_ADDR;
            o_irq <= 1'b0;
            o_flash_erase <= 1'b0;
            o_flash_write <= 1'b0;
            o_buf_rd_data <= 16'h0000;
            o_buf_rd_valid <= 1'b0;
        end else begin
            state <= next_state;
            ctrl <= next_ctrl;
            win_cnt <= next_win_cnt;
            rd_cnt <= next_rd_cnt;
            op_cnt <= next_op_cnt;
            page <= next_page;
            lock_bits <= next_lock_bits;
            rdata <= next_rdata;
            lpm_data <= next_lpm_data;
            lpm_valid <= next_lpm_valid;
            halt <= next_halt;
            o_reset_vector <= reset_vector;
            o_irq <= irq;
            o_flash_erase <= (next_state == FSPC_BUSY) && next_ctrl[FSPC_BIT_ERASE];
            o_flash_write <= (next_state == FSPC_BUSY) && next_ctrl[FSPC_BIT_WRITE];
            o_buf_rd_data <= buf_rd_data;
            o_buf_rd_valid <= buf_rd_valid;
        end
    end

    assign o_rdata = rdata;
    assign o_lpm_data = lpm_data;
    assign o_lpm_valid = lpm_valid;
    assign o_cpu_halt = halt;
    assign o_rww_blocked = ctrl[FSPC_BIT_BUSY];
    assign o_flash_page = page;
endmodule

// ### rtl/fspc_page_buffer.sv
// Temporary page buffer: word-addressed store with per-word valid bits.
// Assumes loads come from the controller one word at a time.
module fspc_page_buffer #(
    parameter int WORD_BITS = 6
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_load,
    input wire logic i_clear,
    input wire logic [WORD_BITS-1:0] i_word_sel,
    input wire logic [15:0] i_data,
    input wire logic [WORD_BITS-1:0] i_rd_sel,
    output logic [15:0] o_rd_data,
    output logic o_rd_valid
);
    localparam int DEPTH = 1 << WORD_BITS;
    logic [15:0] mem [DEPTH];
    logic [DEPTH-1:0] valid;
    logic [DEPTH-1:0] next_valid;

    // ----------------------------------------
    // Valid tracking
    // ----------------------------------------
    always_comb begin
        next_valid = valid;
        if (i_clear) begin
            next_valid = '0;
        end else if (i_load) begin
            next_valid[i_word_sel] = 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            valid <= '0;
        end else begin
            valid <= next_valid;
        end
    end

    // Data array has no reset; valid bits cover it
    always_ff @(posedge i_clk) begin
        if (i_load && !i_clear) begin
            mem[i_word_sel] <= i_data;
        end
    end

    assign o_rd_data = mem[i_rd_sel];
    assign o_rd_valid = valid[i_rd_sel];
endmodule

// ### test/flash_self_program_control_tb.sv
// Self-checking bench for the self-programming controller.
// Assumes package, design, CPU model and checker are compiled first.
module flash_self_program_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fspc_pkg::*;
    // ------------------------------
    // Signals
    // ------------------------------
    localparam int OPC = 4; // Short operations keep the run brief
    localparam logic [15:0] BOOT = 16'h1c00;
    localparam logic [7:0] FUSE_LO = 8'h5a;
    localparam logic [7:0] FUSE_HI = 8'hc3;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic gie = 1'b0;
    logic ee_busy = 1'b0;
    logic fuse = 1'b1;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00;
    logic [5:0] buf_sel = 6'h00;
    logic store, lpm, irq, halt, blocked, lpm_v, ers, wrt, buf_v;
    logic [7:0] rdata, lpm_data;
    logic [15:0] ptr, dw, rvec, buf_data;
    logic [6:0] page;
    logic [15:0] lp_ptr [3] = '{16'h0001, 16'h0000, 16'h0003};
    logic [7:0] lp_exp [3] = '{8'hf3, FUSE_LO, FUSE_HI};
    int n_mismatch = 0;
    int check_count = 0;
    int cycles = 0;
    always #12.5 clk = ~clk;
    fspc_ctrl #(.OP_CYCLES(OPC), .BOOT_START_ADDR(BOOT)) u_dut (
        .i_clk(clk), .i_reset_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_store(store), .i_load_prog(lpm), .i_pointer(ptr), .i_data_word(dw), .i_global_irq_en(gie),
        .i_eeprom_busy(ee_busy), .i_boot_vector_fuse(fuse), .i_fuse_low(FUSE_LO), .i_fuse_high(FUSE_HI),
        .o_reset_vector(rvec), .o_irq(irq), .o_cpu_halt(halt), .o_rww_blocked(blocked), .o_lpm_data(lpm_data),
        .o_lpm_valid(lpm_v), .o_flash_erase(ers), .o_flash_write(wrt), .o_flash_page(page),
        .o_buf_rd_data(buf_data), .o_buf_rd_valid(buf_v), .i_buf_rd_sel(buf_sel));
    fspc_cpu_model u_cpu (.i_clk(clk), .o_store(store), .o_load_prog(lpm), .o_pointer(ptr), .o_data_word(dw));
    // ------------------------------
    // Tasks
    // ------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    task automatic op(input logic [7:0] c, input logic lp, input logic [15:0] p, input logic [15:0] d);
        reg_wr(FSPC_ADDR_CTRL, c);
        u_cpu.issue(lp, p, d);
    endtask
    task automatic wait_op(input logic want);
        repeat (40) begin
            @(posedge clk);
            #1;
            if ((ers | wrt) === want) break;
        end
        chk(ers | wrt, want);
    endtask
    task automatic peek(input logic [5:0] s, input logic [15:0] d, input logic v);
        buf_sel <= s;
        idle(1);
        chk(buf_v, v);
        if (v === 1'b1) chk(buf_data, d);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Hang guard, far above the fewer than two hundred cycles the sequence needs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    // ------------------------------
    // Sequence
    // ------------------------------
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(FSPC_ADDR_CTRL, FSPC_CTRL_RESET);
        rd_chk(FSPC_ADDR_LOCK, 8'hff);
        rd_chk(2'h3, 8'h00);
        chk(rvec, FSPC_APP_RESET_ADDR);
        fuse <= 1'b0;
        idle(2);
        chk(rvec, BOOT);
        reg_wr(FSPC_ADDR_CTRL, 8'h87);
        gie <= 1'b1;
        idle(2);
        chk(irq, 1'b1);
        rd_chk(FSPC_ADDR_CTRL, 8'h80);
        reg_wr(FSPC_ADDR_CTRL, 8'h81);
        idle(1);
        chk(irq, 1'b0);
        u_cpu.issue(1'b0, 16'h0007, 16'ha5a5);
        idle(2);
        chk(irq, 1'b1);
        op(8'h01, 1'b0, 16'h0002, 16'h1234);
        peek(6'h03, 16'ha5a5, 1'b1);
        peek(6'h01, 16'h1234, 1'b1);
        op(8'h03, 1'b0, 16'h0100, 16'hffff);
        wait_op(1'b1);
        chk(blocked, 1'b1);
        chk(halt, 1'b0);
        op(8'h11, 1'b0, 16'h0000, 16'h0000);
        chk(page, 7'h02);
        wait_op(1'b0);
        idle(2);
        chk(blocked, 1'b1);
        op(8'h01, 1'b0, 16'h0004, 16'hbeef);
        idle(2);
        chk(blocked, 1'b0);
        peek(6'h03, 16'ha5a5, 1'b1);
        op(8'h05, 1'b0, 16'h0100, 16'h0000);
        wait_op(1'b1);
        chk(wrt, 1'b1);
        chk(blocked, 1'b1);
        wait_op(1'b0);
        idle(2);
        peek(6'h03, 16'h0000, 1'b0);
        op(8'h11, 1'b0, 16'h0000, 16'h0000);
        idle(2);
        chk(blocked, 1'b0);
        op(8'h01, 1'b0, 16'h000a, 16'h5555);
        op(8'h11, 1'b0, 16'h0000, 16'h0000);
        peek(6'h05, 16'h0000, 1'b0);
        op(8'h01, 1'b0, 16'h000c, 16'h6666);
        peek(6'h06, 16'h6666, 1'b1);
        reg_wr(FSPC_ADDR_CTRL, 8'h01);
        reg_wr(FSPC_ADDR_CTRL, 8'h11);
        peek(6'h06, 16'h0000, 1'b0);
        op(8'h03, 1'b0, 16'h3800, 16'h0000);
        wait_op(1'b1);
        chk(halt, 1'b1);
        chk(page, 7'h70);
        rd_chk(FSPC_ADDR_STATUS, 8'h01);
        wait_op(1'b0);
        idle(2);
        reg_wr(FSPC_ADDR_CTRL, 8'h03);
        idle(3);
        u_cpu.issue(1'b0, 16'h0100, 16'h0000);
        idle(3);
        chk(ers, 1'b0);
        ee_busy <= 1'b1;
        op(8'h03, 1'b0, 16'h0100, 16'h0000);
        idle(2);
        chk(ers, 1'b0);
        op(8'h09, 1'b1, 16'h0001, 16'h0000);
        #1 chk(lpm_v, 1'b0);
        ee_busy <= 1'b0;
        idle(2);
        op(8'h09, 1'b0, 16'h0000, 16'h00f3);
        idle(2);
        rd_chk(FSPC_ADDR_LOCK, 8'hf3);
        foreach (lp_ptr[k]) begin
            op(8'h09, 1'b1, lp_ptr[k], 16'h0000);
            #1 chk(lpm_data, lp_exp[k]);
            chk(lpm_v, 1'b1);
            idle(3);
        end
        print_verdict();
    end
endmodule

bind fspc_ctrl fspc_ctrl_monitor #(.PAGE_BITS(PAGE_BITS), .OP_CYCLES(OP_CYCLES), .BOOT_START_ADDR(BOOT_START_ADDR),
    .NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE(NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE)) u_mon (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_store(i_store), .i_load_prog(i_load_prog), .i_global_irq_en(i_global_irq_en),
    .i_eeprom_busy(i_eeprom_busy), .i_boot_vector_fuse(i_boot_vector_fuse), .o_reset_vector(o_reset_vector),
    .o_irq(o_irq), .o_cpu_halt(o_cpu_halt), .o_rww_blocked(o_rww_blocked), .o_lpm_valid(o_lpm_valid),
    .o_flash_erase(o_flash_erase), .o_flash_write(o_flash_write), .o_flash_page(o_flash_page));

// ### test/fspc_cpu_model.sv
// CPU core model issuing store and load-program instructions.
// Driven by the bench through issue(); shares the block's clock.
module fspc_cpu_model (
    input wire logic i_clk,
    output logic o_store,
    output logic o_load_prog,
    output logic [15:0] o_pointer,
    output logic [15:0] o_data_word
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_store = 1'b0;
        o_load_prog = 1'b0;
        o_pointer = 16'h0000;
        o_data_word = 16'h0000;
    end
    // Operands are valid only with the strobe; inverted after, as a core reuses them
    task automatic issue(input logic lp, input logic [15:0] p, input logic [15:0] d);
        @(posedge i_clk);
        o_store <= !lp;
        o_load_prog <= lp;
        o_pointer <= p;
        o_data_word <= d;
        @(posedge i_clk);
        o_store <= 1'b0;
        o_load_prog <= 1'b0;
        o_pointer <= ~p;
        o_data_word <= ~d;
    endtask
endmodule

// ### test/fspc_ctrl_monitor.sv
// Port checker for the self-programming controller.
// Bound onto fspc_ctrl by the bench; sees its ports only.
module fspc_ctrl_monitor
    import fspc_pkg::*;
#(
    parameter int PAGE_BITS = 7,
    parameter int OP_CYCLES = 16,
    parameter logic [15:0] BOOT_START_ADDR = 16'h1c00,
    parameter logic [PAGE_BITS-1:0] NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE = 7'h70
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_store,
    input wire logic i_load_prog,
    input wire logic i_global_irq_en,
    input wire logic i_eeprom_busy,
    input wire logic i_boot_vector_fuse,
    input wire logic [15:0] o_reset_vector,
    input wire logic o_irq,
    input wire logic o_cpu_halt,
    input wire logic o_rww_blocked,
    input wire logic o_lpm_valid,
    input wire logic o_flash_erase,
    input wire logic o_flash_write,
    input wire logic [PAGE_BITS-1:0] o_flash_page
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);
    // ------------------------------
    // Operation length
    // ------------------------------
    logic op_on;
    logic [7:0] op_cnt;
    assign op_on = o_flash_erase | o_flash_write;
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) op_cnt <= 8'h00;
        else op_cnt <= op_on ? op_cnt + 8'h01 : 8'h00;
    end
    // Only an idle block accepts a new command
    sequence s_arm_erase;
        i_wr && i_addr == FSPC_ADDR_CTRL && i_wdata[4:0] == FSPC_PAT_ERASE && !i_eeprom_busy && !op_on;
    endsequence
    sequence s_late_store;
        !i_store [*4] ##1 i_store;
    endsequence
    chk_erase_start: assert property (s_arm_erase ##[1:4] i_store |=> o_flash_erase)
        else $error("erase missing after store in window");
    chk_window_expiry: assert property (s_arm_erase ##1 s_late_store |=> !o_flash_erase)
        else $error("erase after window closed");
    chk_op_length: assert property ($fell(op_on) |-> op_cnt == OP_CYCLES)
        else $error("operation length off");
    chk_halt_no_read_while_write_section: assert property ($rose(o_cpu_halt) |-> op_on && o_flash_page >= NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE)
        else $error("halt without upper section operation");
    chk_busy_rww: assert property ($rose(op_on) && o_flash_page < NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE |-> o_rww_blocked && !o_cpu_halt)
        else $error("lower section operation not flagged busy");
    chk_irq_global: assert property (o_irq |-> $past(i_global_irq_en))
        else $error("irq without global enable");
    chk_lpm_answer: assert property (o_lpm_valid |-> $past(i_load_prog))
        else $error("readback without load");
    chk_eeprom_block: assert property (i_eeprom_busy && i_load_prog |=> !o_lpm_valid)
        else $error("readback during eeprom write");
    chk_vector_fuse: assert property ($past(i_reset_n) |->
        o_reset_vector == ($past(i_boot_vector_fuse) ? FSPC_APP_RESET_ADDR : BOOT_START_ADDR))
        else $error("reset vector does not follow fuse");
endmodule
